// >>> pxtd_consts.svh
// Constants for the bus target decode and command block
`ifndef PXTD_CONSTS_SVH
`define PXTD_CONSTS_SVH
// Command codes
`define PXTD_CMD_INTACK   4'h0
`define PXTD_CMD_SPECIAL  4'h1
`define PXTD_CMD_IORD     4'h2
`define PXTD_CMD_IOWR     4'h3
`define PXTD_CMD_RSV4     4'h4
`define PXTD_CMD_RSV5     4'h5
`define PXTD_CMD_MRD      4'h6
`define PXTD_CMD_MWR      4'h7
`define PXTD_CMD_ALRD     4'h8
`define PXTD_CMD_ALWR     4'h9
`define PXTD_CMD_CFGRD    4'hA
`define PXTD_CMD_CFGWR    4'hB
`define PXTD_CMD_MRDMUL   4'hC
`define PXTD_CMD_DAC      4'hD
`define PXTD_CMD_MRDLINE  4'hE
`define PXTD_CMD_MWRINV   4'hF
// Configuration address fields
`define PXTD_CFG_FN_LSB   8
`define PXTD_CFG_FN_MSB   10
`define PXTD_CFG_DW_LSB   2
`define PXTD_CFG_DW_MSB   7
`define PXTD_CFG_TYPE0    2'h0
`define PXTD_FN0          3'h0
`define PXTD_FN1          3'h1
// Window sizes as address bit counts
`define PXTD_IO_BITS      8
`define PXTD_MEM_BITS     16
// Command register enable bits
`define PXTD_CMDREG_IO    0
`define PXTD_CMDREG_MEM   1
`endif

// >>> pxtd_pkg.sv
// Types for the bus target decode and command block
package pxtd_pkg;
	// Target decode class
	typedef enum logic [5:0]
	{
		PXTD_T_NONE  = 6'h01,
		PXTD_T_CFG   = 6'h02,
		PXTD_T_IO    = 6'h04,
		PXTD_T_MEM0  = 6'h08,
		PXTD_T_MEM1  = 6'h10,
		PXTD_T_HOLD  = 6'h20
	} pxtd_state_e;
	// Decoded target claim
	typedef struct packed
	{
		logic       hit;
		logic       fn;
		logic [1:0] space;
		logic       write;
		logic [3:0] op;
		logic [5:0] dword;
		logic [3:0] byte_en;
	} pxtd_claim_s;
endpackage

// >>> pxtd_decode.sv
// Address-phase target decode and master command filter
//
// Overview of operation
// - Config cycles need select asserted
// - Bits 10:8 pick function zero or one
// - Bits 7:2 index one of 64 Dwords
// - Only Type 0 config accepted
// - Byte enables pick config bytes
// - Upper address ignored for config
// - I/O claimed within 256-byte window
// - I/O decode uses low 32 bits
// - Two 64 KB memory windows decoded
// - Interrupt ack and special cycle ignored
// - Reserved codes ignored, never issued
// - I/O read/write both roles, modes
// - 0110 is single-Dword read extended mode
// - Memory write both roles, modes
// - Block aliases target-only, extended mode
// - Config commands target-only
// - Cache commands map to plain memory outside extended mode
// - Dual address cycle supported both roles
// - One shared request/grant pair
// - Separate interrupt per function
// - Up to 64-bit wide bus
`timescale 1ns/10ps
`default_nettype none
`include "pxtd_consts.svh"
module pxtd_decode
	import pxtd_pkg::*;
#(
	parameter int ADDR_W = 64
)
(
	input  wire logic              clock,          // Bus clock
	input  wire logic              rst,            // Async reset, high
	input  wire logic              addr_valid,     // Address phase strobe
	input  wire logic [ADDR_W-1:0] ad,             // Address lines
	input  wire logic [3:0]        cmd,            // Command code
	input  wire logic [3:0]        byte_en_n,      // Byte enables, low
	input  wire logic              cfg_sel,        // Config select
	input  wire logic              ext_mode,       // Extended bus mode
	input  wire logic [1:0]        cmd_reg_en0,    // Fn0 space enables
	input  wire logic [1:0]        cmd_reg_en1,    // Fn1 space enables
	input  wire logic [31:0]       io_base,        // I/O window base
	input  wire logic [63:0]       mem0_base,      // Window zero base
	input  wire logic [63:0]       mem1_base,      // Window one base
	input  wire logic [1:0]        func_req,       // Per-function requests
	input  wire logic              bus_gnt_n,      // Shared grant, low
	input  wire logic [1:0]        func_irq,       // Per-function events
	input  wire logic [3:0]        mst_cmd,        // Command to issue
	input  wire logic              mst_start,      // Issue strobe
	output var  logic              claim_valid,    // Claim result pulse
	output var  pxtd_claim_s       claim,          // Claim details
	output var  logic              bus_req_n,      // Shared request, low
	output var  logic [1:0]        func_gnt,       // Internal grant
	output var  logic [1:0]        irq_n,          // Interrupts, low
	output var  logic              mst_valid,      // Issue accepted
	output var  logic [3:0]        mst_cmd_out,    // Command driven
	output var  logic              mst_reject      // Issue refused
);
	// Space codes carried in claim.space
	localparam logic [1:0] SP_CFG = 2'h0;
	localparam logic [1:0] SP_IO  = 2'h1;
	localparam logic [1:0] SP_M0  = 2'h2;
	localparam logic [1:0] SP_M1  = 2'h3;

	// Operation codes carried in claim.op
	localparam logic [3:0] OP_RD    = 4'h1;
	localparam logic [3:0] OP_WR    = 4'h2;
	localparam logic [3:0] OP_RDDW  = 4'h3;
	localparam logic [3:0] OP_RDBLK = 4'h4;
	localparam logic [3:0] OP_WRBLK = 4'h5;

	// Window match on upper address bits
	function automatic logic win_hit(input logic [63:0] a,
		input logic [63:0] b, input int bits);
		logic [63:0] m;
		m = ~64'h0 << bits;
		return ((a ^ b) & m) == 64'h0;
	endfunction

	// Commands this device may issue as master
	function automatic logic mst_ok(input logic [3:0] c, input logic x);
		logic ok;
		ok = 1'b0;
		case (c)
			`PXTD_CMD_IORD, `PXTD_CMD_IOWR: ok = 1'b1;
			`PXTD_CMD_MRD, `PXTD_CMD_MWR:   ok = 1'b1;
			`PXTD_CMD_MRDMUL:               ok = 1'b1;
			`PXTD_CMD_DAC:                  ok = 1'b1;
			`PXTD_CMD_MRDLINE:              ok = 1'b1;
			`PXTD_CMD_MWRINV:               ok = 1'b1;
			default:                        ok = 1'b0;
		endcase
		return ok;
	endfunction

	// Dual address state
	pxtd_state_e  state_reg;
	logic [31:0]  dac_lo_reg;      // Low half from DAC phase
	logic [63:0]  full_addr;       // Assembled address
	logic [3:0]   be;              // Active-high byte enables
	logic [2:0]   fn_field;        // Function select field
	logic         fn_ok;           // Function exists
	logic         fn_sel;          // Function index
	logic [1:0]   en_sel;          // Enables of hit function
	logic         io_hit;
	logic         m0_hit;
	logic         m1_hit;
	pxtd_claim_s  claim_next;

	// Address assembly for 64-bit addressing
	always_comb
	begin
		full_addr = 64'h0;
		full_addr[ADDR_W-1:0] = ad;
		if (state_reg == PXTD_T_HOLD)
			full_addr = {ad[31:0], dac_lo_reg};
	end

	// Track dual address cycles
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state_reg  <= PXTD_T_NONE;
			dac_lo_reg <= 32'h0;
		end
		else if (addr_valid && cmd == `PXTD_CMD_DAC &&
			state_reg != PXTD_T_HOLD)
		begin
			state_reg  <= PXTD_T_HOLD;
			dac_lo_reg <= ad[31:0];
		end
		else if (addr_valid)
			state_reg <= PXTD_T_NONE;
	end

	// Target decode of the address phase
	always_comb
	begin
		be       = ~byte_en_n;
		fn_field = ad[`PXTD_CFG_FN_MSB:`PXTD_CFG_FN_LSB];
		fn_ok    = fn_field == `PXTD_FN0 || fn_field == `PXTD_FN1;
		fn_sel   = fn_field == `PXTD_FN1;
		io_hit   = win_hit({32'h0, full_addr[31:0]},
			{32'h0, io_base}, `PXTD_IO_BITS);
		m0_hit   = win_hit(full_addr, mem0_base, `PXTD_MEM_BITS);
		m1_hit   = win_hit(full_addr, mem1_base, `PXTD_MEM_BITS);
		en_sel   = (m1_hit && !m0_hit) ? cmd_reg_en1 : cmd_reg_en0;
		// I/O space always answers to function zero enables
		if (cmd == `PXTD_CMD_IORD || cmd == `PXTD_CMD_IOWR)
			en_sel = cmd_reg_en0;
		claim_next          = '0;
		claim_next.byte_en  = be;
		claim_next.dword    = ad[`PXTD_CFG_DW_MSB:`PXTD_CFG_DW_LSB];
		case (cmd)
			`PXTD_CMD_CFGRD, `PXTD_CMD_CFGWR:
			begin
				claim_next.hit = cfg_sel && fn_ok &&
					ad[1:0] == `PXTD_CFG_TYPE0;
				claim_next.fn    = fn_sel;
				claim_next.space = SP_CFG;
				claim_next.write = cmd == `PXTD_CMD_CFGWR;
				claim_next.op    = claim_next.write ? OP_WR : OP_RD;
			end
			`PXTD_CMD_IORD, `PXTD_CMD_IOWR:
			begin
				claim_next.hit   = io_hit && en_sel[`PXTD_CMDREG_IO];
				claim_next.space = SP_IO;
				claim_next.write = cmd == `PXTD_CMD_IOWR;
				claim_next.op    = claim_next.write ? OP_WR : OP_RD;
			end
			`PXTD_CMD_MRD, `PXTD_CMD_MWR, `PXTD_CMD_ALRD,
			`PXTD_CMD_ALWR, `PXTD_CMD_MRDMUL, `PXTD_CMD_MRDLINE,
			`PXTD_CMD_MWRINV:
			begin
				claim_next.hit = (m0_hit || m1_hit) &&
					en_sel[`PXTD_CMDREG_MEM];
				if (!ext_mode && (cmd == `PXTD_CMD_ALRD ||
					cmd == `PXTD_CMD_ALWR))
					claim_next.hit = 1'b0;
				// Split completions are outside this block
				if (ext_mode && cmd == `PXTD_CMD_MRDMUL)
					claim_next.hit = 1'b0;
				claim_next.fn    = m1_hit && !m0_hit;
				claim_next.space = m0_hit ? SP_M0 : SP_M1;
				claim_next.write = cmd == `PXTD_CMD_MWR ||
					cmd == `PXTD_CMD_ALWR || cmd == `PXTD_CMD_MWRINV;
				if (!ext_mode)
					claim_next.op = claim_next.write ? OP_WR : OP_RD;
				else if (cmd == `PXTD_CMD_MRD)
					claim_next.op = OP_RDDW;
				else if (cmd == `PXTD_CMD_MWR)
					claim_next.op = OP_WR;
				else
					claim_next.op = claim_next.write ? OP_WRBLK : OP_RDBLK;
			end
			default:
				claim_next.hit = 1'b0;
		endcase
	end

	// Register claim result
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			claim_valid <= 1'b0;
			claim       <= '0;
		end
		else
		begin
			claim_valid <= addr_valid && cmd != `PXTD_CMD_DAC;
			claim       <= (addr_valid && cmd != `PXTD_CMD_DAC) ?
				claim_next : '0;
		end
	end

	// Master command filter
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			mst_valid   <= 1'b0;
			mst_reject  <= 1'b0;
			mst_cmd_out <= 4'h0;
		end
		else
		begin
			mst_valid   <= mst_start && mst_ok(mst_cmd, ext_mode);
			mst_reject  <= mst_start && !mst_ok(mst_cmd, ext_mode);
			mst_cmd_out <= (mst_start && mst_ok(mst_cmd, ext_mode)) ?
				mst_cmd : 4'h0;
		end
	end

	// Round robin owner of the shared request
	logic last_reg;
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			bus_req_n <= 1'b1;
			func_gnt  <= 2'h0;
			last_reg  <= 1'b0;
		end
		else
		begin
			bus_req_n <= ~|func_req;
			if (!bus_gnt_n && func_gnt == 2'h0 && |func_req)
			begin
				if (func_req[~last_reg])
				begin
					func_gnt <= last_reg ? 2'h1 : 2'h2;
					last_reg <= ~last_reg;
				end
				else
					func_gnt <= last_reg ? 2'h2 : 2'h1;
			end
			else if (bus_gnt_n || (func_gnt & func_req) == 2'h0)
				func_gnt <= 2'h0;
		end
	end

	// Separate interrupt per function
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			irq_n <= 2'h3;
		else
			irq_n <= ~func_irq;
	end

	AST_CFG_SEL: assert property (@(posedge clock) disable iff (rst)
		addr_valid && !cfg_sel && (cmd == `PXTD_CMD_CFGRD ||
		cmd == `PXTD_CMD_CFGWR) |=> !claim.hit)
		else $error("config claimed without select");

	AST_TYPE1: assert property (@(posedge clock) disable iff (rst)
		addr_valid && ad[1:0] != 2'h0 && (cmd == `PXTD_CMD_CFGRD ||
		cmd == `PXTD_CMD_CFGWR) |=> !claim.hit)
		else $error("non-type-0 config claimed");

	AST_FN: assert property (@(posedge clock) disable iff (rst)
		addr_valid && ad[10:9] != 2'h0 && cmd == `PXTD_CMD_CFGRD
		|=> !claim.hit)
		else $error("missing function claimed");

	AST_DW: assert property (@(posedge clock) disable iff (rst)
		addr_valid && cmd == `PXTD_CMD_CFGWR
		|=> claim.dword == $past(ad[7:2]))
		else $error("dword index wrong");

	AST_BE: assert property (@(posedge clock) disable iff (rst)
		addr_valid && cmd == `PXTD_CMD_CFGRD
		|=> claim.byte_en == ~$past(byte_en_n))
		else $error("byte enables wrong");

	AST_IGN: assert property (@(posedge clock) disable iff (rst)
		addr_valid && cmd[3:1] == 3'h0 |=> !claim.hit)
		else $error("ignored command claimed");

	AST_MST: assert property (@(posedge clock) disable iff (rst)
		mst_start && (mst_cmd == `PXTD_CMD_RSV4 ||
		mst_cmd == `PXTD_CMD_CFGRD) |=> mst_reject && !mst_valid)
		else $error("forbidden command issued");

	AST_IOEN: assert property (@(posedge clock) disable iff (rst)
		addr_valid && !cmd_reg_en0[0] && cmd == `PXTD_CMD_IORD
		|=> !claim.hit)
		else $error("I/O claimed while disabled");
endmodule
`default_nettype wire

// >>> pxtd_host.sv
// Host bridge model: address phases and shared bus grant
`timescale 1ns/10ps
`default_nettype none
module pxtd_host
(
	input  wire logic        clock,      // Bus clock
	input  wire logic        bus_req_n,  // Request from device, low
	input  wire logic [3:0]  gnt_dly,    // Grant latency in cycles
	output var  logic        bus_gnt_n,  // Grant to device, low
	output var  logic        addr_valid, // Address phase strobe
	output var  logic [63:0] ad,         // Address lines
	output var  logic [3:0]  cmd,        // Command code
	output var  logic [3:0]  byte_en_n,  // Byte enables, low
	output var  logic        cfg_sel     // Config select
);
	int wait_cnt = 0; // Cycles the request has waited
	// Quiet bus at start
	initial
	begin
		bus_gnt_n = 1'b1;
		addr_valid = 1'b0;
		ad = 64'h0;
		cmd = 4'h0;
		byte_en_n = 4'hF;
		cfg_sel = 1'b0;
	end
	// Grant only after the chosen latency, slow or prompt
	always @(negedge clock)
	begin
		wait_cnt <= bus_req_n ? 0 : wait_cnt + 1;
		bus_gnt_n <= !(!bus_req_n && wait_cnt >= int'(gnt_dly));
	end
	task automatic phase(input logic [3:0] c, input logic [63:0] a,
		input logic [3:0] be, input logic sel);
	begin
		addr_valid = 1'b1;
		cmd = c;
		ad = a;
		byte_en_n = be;
		cfg_sel = sel;
		@(negedge clock);
	end
	endtask
	// Idle lines flip so stale values never match
	task automatic idle();
	begin
		addr_valid = 1'b0;
		ad = ~ad;
		cmd = ~cmd;
		byte_en_n = ~byte_en_n;
		cfg_sel = 1'b0;
	end
	endtask
endmodule
`default_nettype wire

// >>> test_pcix_target_decode_cmd.sv
// Self-checking bench for the target decode block
`timescale 1ns/10ps
`default_nettype none
module test_pcix_target_decode_cmd
	import pxtd_pkg::*;
;
	localparam logic [18:0] ALL = 19'h7FFFF; // Whole claim
	localparam logic [18:0] KIND = 19'h7FC00; // Claim without dword, lanes
	localparam logic [18:0] HIT = 19'h40000; // Hit flag only
	logic clock = 1'b0, rst = 1'b1, ext_mode = 1'b0, mst_start = 1'b0;
	logic [1:0] en0 = 2'h3, en1 = 2'h3, func_req = 2'h0, func_irq = 2'h0;
	logic [31:0] io_base = 32'h0000_1200; // I/O window
	logic [63:0] mem0_base = 64'h0000_0000_ABCD_0000; // Window zero
	logic [63:0] mem1_base = 64'h0000_0001_5555_0000; // Window one
	logic [3:0] mst_cmd = 4'h0, gnt_dly = 4'h1;
	logic addr_valid, cfg_sel, bus_gnt_n, claim_valid, bus_req_n;
	logic mst_valid, mst_reject;
	logic [63:0] ad;
	logic [3:0] cmd, byte_en_n, mst_cmd_out;
	logic [1:0] func_gnt, irq_n;
	pxtd_claim_s claim;
	int err_total = 0, cmp_count = 0;
	// Clock at 50 MHz
	always #10 clock = ~clock;
	pxtd_host u_host (.clock(clock), .bus_req_n(bus_req_n),
		.gnt_dly(gnt_dly), .bus_gnt_n(bus_gnt_n), .addr_valid(addr_valid),
		.ad(ad), .cmd(cmd), .byte_en_n(byte_en_n), .cfg_sel(cfg_sel));
	pxtd_decode #(.ADDR_W(64)) u_dut (.clock(clock), .rst(rst),
		.addr_valid(addr_valid), .ad(ad), .cmd(cmd),
		.byte_en_n(byte_en_n), .cfg_sel(cfg_sel), .ext_mode(ext_mode),
		.cmd_reg_en0(en0), .cmd_reg_en1(en1), .io_base(io_base),
		.mem0_base(mem0_base), .mem1_base(mem1_base),
		.func_req(func_req), .bus_gnt_n(bus_gnt_n), .func_irq(func_irq),
		.mst_cmd(mst_cmd), .mst_start(mst_start),
		.claim_valid(claim_valid), .claim(claim), .bus_req_n(bus_req_n),
		.func_gnt(func_gnt), .irq_n(irq_n), .mst_valid(mst_valid),
		.mst_cmd_out(mst_cmd_out), .mst_reject(mst_reject));
	// Counts, verdict, end of run
	task automatic close_out();
	begin
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	end
	endtask
	// Compare and report
	task automatic chk(input string what, input logic [18:0] e,
		input logic [18:0] g);
	begin
		cmp_count++;
		if (g !== e)
		begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	end
	endtask
	// A waited answer that never came ends the run
	task automatic hung(input string what);
	begin
		err_total++;
		$display("BAD %s expected answer seen none", what);
		close_out();
	end
	endtask
	// Expected claim of a hit
	function automatic logic [18:0] cl(input logic f, input logic [1:0] s,
		input logic w, input logic [3:0] o, input logic [5:0] d,
		input logic [3:0] b);
		return {1'b1, f, s, w, o, d, b};
	endfunction
	// Address phase (dual cycle if asked), then judge the claim
	task automatic txn(input string what, input logic dac,
		input logic [3:0] c, input logic [63:0] a, input logic [3:0] be,
		input logic sel, input logic [18:0] e, input logic [18:0] m);
		bit seen;
	begin
		seen = 0;
		if (dac)
			u_host.phase(4'hD, {32'h0, a[31:0]}, be, sel);
		u_host.phase(c, dac ? {32'h0, a[63:32]} : a, be, sel);
		u_host.idle();
		for (int i = 0; i < 3 && !seen; i++)
			if (claim_valid === 1'b1)
			begin
				seen = 1;
				chk(what, e & m, claim & m);
			end
			else
				@(negedge clock);
		if (!seen)
			hung(what);
		// Let an idle edge pass before the next request
		@(negedge clock);
	end
	endtask
	task automatic t_cfg();
	begin
		txn("cfg rd", 0, 4'hA, 64'h104, 4'h0, 1, cl(1, 0, 0, 1, 1, 4'hF),
			ALL);
		txn("cfg wr", 0, 4'hB, 64'hDEAD_BEEF_1234_F8FC, 4'h5, 1,
			cl(0, 0, 1, 2, 6'h3F, 4'hA), ALL);
		txn("cfg nosel", 0, 4'hA, 64'h104, 4'h0, 0, 19'h0, HIT);
		txn("cfg fn2", 0, 4'hA, 64'h204, 4'h0, 1, 19'h0, HIT);
		txn("cfg type1", 0, 4'hB, 64'h101, 4'h0, 1, 19'h0, HIT);
		$display("test cfg done");
	end
	endtask
	task automatic t_io();
	begin
		txn("io rd", 0, 4'h2, 64'hFFFF_FFFF_0000_12FC, 4'h0, 0,
			cl(0, 1, 0, 1, 0, 0), KIND);
		ext_mode = 1'b1;
		txn("io wr ext", 0, 4'h3, 64'h1200, 4'h0, 0, cl(0, 1, 1, 2, 0, 0),
			KIND);
		txn("io out", 0, 4'h2, 64'h1300, 4'h0, 0, 19'h0, HIT);
		en0 = 2'h2;
		txn("io off", 0, 4'h2, 64'h1210, 4'h0, 0, 19'h0, HIT);
		en0 = 2'h1;
		txn("mem off", 0, 4'h7, 64'hABCD_0010, 4'h0, 0, 19'h0, HIT);
		en0 = 2'h3;
		ext_mode = 1'b0;
		$display("test io done");
	end
	endtask
	task automatic t_mem();
		logic [3:0] c, op;
		logic [63:0] tbl;
		logic [18:0] want;
	begin
		for (int x = 0; x < 32; x++)
		begin
			c = x[3:0];
			ext_mode = x[4];
			tbl = x[4] ? 64'h5400_0054_2300_0000 : 64'h2101_0000_2100_0000;
			op = tbl[4 * c +: 4];
			// Expected claim of window zero, or none
			want = cl(0, 2, op == 2 || op == 5, op, 0, 0);
			if (op == 0)
				want = 19'h0;
			if (c != 4'hD)
				txn("mem code", 0, c, 64'hABCD_FFF0, 4'h0, 0, want,
					op == 0 ? HIT : KIND);
		end
		txn("mem1 dac", 1, 4'h7, 64'h0000_0001_5555_0010, 4'h0, 0,
			cl(1, 3, 1, 2, 0, 0), KIND);
		txn("mem1 short", 0, 4'h7, 64'h5555_0010, 4'h0, 0, 19'h0,
			HIT);
		ext_mode = 1'b0;
		$display("test mem done");
	end
	endtask
	task automatic t_mst();
		logic rej;
		bit seen;
	begin
		for (int x = 0; x < 32; x++)
		begin
			ext_mode = x[4];
			mst_cmd = x[3:0];
			rej = 16'h0F33 >> x[3:0];
			mst_start = 1'b1;
			@(negedge clock);
			mst_start = 1'b0;
			seen = 0;
			for (int i = 0; i < 3 && !seen; i++)
				if ((mst_valid | mst_reject) === 1'b1)
					seen = 1;
				else
					@(negedge clock);
			if (!seen)
				hung("master");
			else
				chk("master", {13'h0, rej, !rej, rej ? 4'h0 : x[3:0]},
					{13'h0, mst_reject, mst_valid,
					mst_cmd_out});
			// Idle edge before the next strobe
			@(negedge clock);
		end
		ext_mode = 1'b0;
		$display("test master done");
	end
	endtask
	// one shared request, internal grant alternates
	task automatic t_arb(input logic [3:0] dly);
		logic [1:0] first;
	begin
		gnt_dly = dly;
		func_req = 2'h3;
		for (int i = 0; i < 40 && func_gnt === 2'h0; i++)
			@(negedge clock);
		if (func_gnt === 2'h0)
			hung("first grant");
		first = func_gnt;
		chk("shared req", 19'h0, {18'h0, bus_req_n});
		chk("grant onehot", 19'h1, {18'h0, $onehot(first)});
		func_req = ~first;
		for (int i = 0; i < 40 && func_gnt !== ~first; i++)
			@(negedge clock);
		if (func_gnt !== ~first)
			hung("grant next");
		chk("grant next", {17'h0, ~first}, {17'h0, func_gnt});
		func_req = 2'h0;
		repeat (4) @(negedge clock);
		$display("test arbiter done");
	end
	endtask
	task automatic t_irq();
	begin
		for (int x = 1; x < 4; x++)
		begin
			func_irq = x[1:0];
			repeat (2) @(negedge clock);
			chk("irq", {17'h0, ~x[1:0]}, {17'h0, irq_n});
		end
		func_irq = 2'h0;
		$display("test irq done");
	end
	endtask
	// Main sequence
	initial
	begin
		repeat (2) @(negedge clock);
		rst = 1'b0;
		chk("reset", 19'h7, {7'h0, claim_valid, mst_valid, mst_reject,
			mst_cmd_out, func_gnt, bus_req_n, irq_n});
		chk("reset claim", 19'h0, claim);
		t_cfg();
		t_io();
		t_mem();
		t_mst();
		t_arb(4'h1);
		t_arb(4'h6);
		t_irq();
		close_out();
	end
endmodule
`default_nettype wire
